/* core/pdl_ctrl.sv */
// Phase delay lock controller top: registers, search and track engine, lock flags.
`timescale 1ns/100ps
module pdl_ctrl #(
  parameter int unsigned LOCK_CYCLES = pdl_pkg::LOCK_CYC_DEF
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_csb_i,
  input wire logic spi_sdi_i,
  input wire logic [4:0] meas_phase_i,
  input wire logic receiver_locked_flag_i,
  input wire logic receiver_lost_flag_i,
  input wire logic receiver_tracking_flag_i,
  input wire logic align_locked_flag_i,
  input wire logic align_lost_flag_i,
  input wire logic align_tracking_flag_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  output logic irq_o,
  output logic [8:0] delay_tap_value_o
);
  logic rst_q_r, rst_n_r;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  logic wr;
  logic [5:0] irq_en_r, irq_en_nxt, irq_st;
  logic [7:0] pd_ctl_r, pd_ctl_nxt, slope_r, slope_nxt, loop_r, loop_nxt;
  logic [7:0] tgt_r, tgt_nxt, dly_r, dly_nxt, srch_r, srch_nxt;
  logic start, stop;
  pdl_pkg::pdl_state_e st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [8:0] delay_nxt, base_r, base_nxt, up_r, up_nxt, dn_r, dn_nxt;
  logic dirup_r, dirup_nxt, wide_r, wide_nxt;
  logic [4:0] ph1_r, ph1_nxt, cur_ph_r, cur_ph_nxt;
  logic locked_r, locked_nxt, lost_r, lost_nxt, ever_r, ever_nxt, fail_r, fail_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [8:0] init_dly, gtaps, lim_hi, lim_lo, step;
  logic [4:0] dev, adev, d2;
  logic can_up, can_dn, pick_up, adv_fail, ph_hit, probe_dn, slope_ok, trk_eval, do_adv, do_load;
  logic searching, overdue;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_q_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_q_r <= 1'b1;
      rst_n_r <= rst_q_r;
    end
  end

  pdl_spi_slave u_spi (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .sclk_i(spi_sclk_i),
    .csb_i(spi_csb_i),
    .sdi_i(spi_sdi_i),
    .rdata_i(rdata),
    .addr_o(addr),
    .wdata_o(wdata),
    .wr_o(wr),
    .sdo_o(spi_sdo_o),
    .sdo_oe_o(spi_sdo_oe_o)
  );

  // Condition order matches the enable and status bit layout.
  pdl_irq u_irq (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .cond_i({align_lost_flag_i, align_locked_flag_i, lost_r, locked_r, receiver_lost_flag_i,
             receiver_locked_flag_i}),
    .en_i(irq_en_r),
    .status_o(irq_st),
    .irq_o(irq_o)
  );

  assign start = wr && (addr == pdl_pkg::A_LOOP) && wdata[pdl_pkg::LC_EN];
  assign stop = wr && (addr == pdl_pkg::A_LOOP) && !wdata[pdl_pkg::LC_EN];

  always_comb begin
    irq_en_nxt = irq_en_r;
    pd_ctl_nxt = pd_ctl_r;
    slope_nxt = slope_r;
    loop_nxt = loop_r;
    tgt_nxt = tgt_r;
    dly_nxt = dly_r;
    srch_nxt = srch_r;
    if (wr) begin
      case (addr)
        pdl_pkg::A_IRQ_EN: irq_en_nxt = wdata[pdl_pkg::IRQ_W-1:0];
        pdl_pkg::A_PD_CTL: pd_ctl_nxt = wdata;
        pdl_pkg::A_SLOPE: slope_nxt = wdata;
        pdl_pkg::A_LOOP: loop_nxt = wdata;
        pdl_pkg::A_TGT: tgt_nxt = wdata;
        pdl_pkg::A_DLY: dly_nxt = wdata;
        pdl_pkg::A_SRCH: srch_nxt = wdata;
        default: irq_en_nxt = irq_en_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_en_r <= 6'h00;
      pd_ctl_r <= 8'h00;
      slope_r <= 8'h00;
      loop_r <= 8'h00;
      tgt_r <= 8'h00;
      dly_r <= 8'h00;
      srch_r <= 8'h00;
    end else begin
      irq_en_r <= irq_en_nxt;
      pd_ctl_r <= pd_ctl_nxt;
      slope_r <= slope_nxt;
      loop_r <= loop_nxt;
      tgt_r <= tgt_nxt;
      dly_r <= dly_nxt;
      srch_r <= srch_nxt;
    end
  end

  always_comb begin
    case (addr)
      pdl_pkg::A_IRQ_EN: rdata = {2'h0, irq_en_r};
      pdl_pkg::A_IRQ_ST: rdata = {2'h0, irq_st};
      pdl_pkg::A_SYNC_ST: rdata = {align_tracking_flag_i, 1'b0, align_lost_flag_i, align_locked_flag_i,
                                   receiver_tracking_flag_i, 1'b0, receiver_lost_flag_i,
                                   receiver_locked_flag_i};
      pdl_pkg::A_PD_CTL: rdata = pd_ctl_r;
      pdl_pkg::A_SLOPE: rdata = slope_r;
      pdl_pkg::A_LOOP: rdata = loop_r;
      pdl_pkg::A_TGT: rdata = loop_r[pdl_pkg::LC_READ] ?
                              {delay_tap_value_o[0], tgt_r[6:5], cur_ph_r} : tgt_r;
      pdl_pkg::A_DLY: rdata = loop_r[pdl_pkg::LC_READ] ? delay_tap_value_o[8:1] : dly_r;
      pdl_pkg::A_SRCH: rdata = srch_r;
      pdl_pkg::A_LSTAT: rdata = {4'h0, fail_r, overdue, lost_r, locked_r};
      default: rdata = 8'h00;
    endcase
  end

  assign init_dly = {dly_r, tgt_r[pdl_pkg::TP_DLY0]};
  assign gtaps = 9'(srch_r[pdl_pkg::GUARD_MSB:0]) << pdl_pkg::GUARD_SHIFT;
  assign lim_hi = wide_r ? pdl_pkg::DLY_MAX : pdl_pkg::DLY_MAX - gtaps;
  assign lim_lo = wide_r ? pdl_pkg::DLY_MIN : gtaps;
  assign can_up = up_r < lim_hi;
  assign can_dn = dn_r > lim_lo;
  assign pick_up = can_up && (dirup_r || !can_dn);
  assign adv_fail = !can_up && !can_dn && wide_r;
  assign dev = pdl_pkg::phase_dev(meas_phase_i, tgt_r[4:0]);
  assign adev = pdl_pkg::mag(dev);
  assign ph_hit = srch_r[pdl_pkg::SC_EXACT] ? (adev == 5'h00) : (adev <= pdl_pkg::TOL_DEV);
  assign probe_dn = (base_r == pdl_pkg::DLY_MAX);
  assign d2 = pdl_pkg::phase_dev(meas_phase_i, ph1_r);
  assign slope_ok = ((!d2[pdl_pkg::PH_MSB] && d2 != 5'h00) ^ probe_dn) == slope_r[pdl_pkg::SL_POS];
  assign trk_eval = (st_r == pdl_pkg::PDL_TRACK) && (cnt_r == pdl_pkg::TRACK_CYC - pdl_pkg::CNT_ONE);
  assign step = loop_r[pdl_pkg::LC_GAIN] ? pdl_pkg::STEP_HI : pdl_pkg::STEP_LO;
  assign searching = (st_r != pdl_pkg::PDL_IDLE) && (st_r != pdl_pkg::PDL_TRACK) && (st_r != pdl_pkg::PDL_FAIL);
  assign overdue = (tmr_r >= LOCK_CYCLES) && !locked_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    delay_nxt = delay_tap_value_o;
    base_nxt = base_r;
    up_nxt = up_r;
    dn_nxt = dn_r;
    dirup_nxt = dirup_r;
    wide_nxt = wide_r;
    ph1_nxt = ph1_r;
    cur_ph_nxt = cur_ph_r;
    locked_nxt = locked_r;
    lost_nxt = lost_r;
    ever_nxt = ever_r;
    fail_nxt = fail_r;
    tmr_nxt = (searching && tmr_r < LOCK_CYCLES) ? tmr_r + 32'h1 : tmr_r;
    do_adv = 1'b0;
    do_load = start;
    case (st_r)
      pdl_pkg::PDL_IDLE: st_nxt = st_r;
      pdl_pkg::PDL_SETTLE, pdl_pkg::PDL_SLPS: begin
        cnt_nxt = cnt_r + pdl_pkg::CNT_ONE;
        if (cnt_r == pdl_pkg::SETTLE_CYC - pdl_pkg::CNT_ONE) begin
          cnt_nxt = 8'h00;
          st_nxt = (st_r == pdl_pkg::PDL_SETTLE) ? pdl_pkg::PDL_MEAS : pdl_pkg::PDL_SLPM;
        end
      end
      pdl_pkg::PDL_MEAS: begin
        cur_ph_nxt = meas_phase_i;
        if (ph_hit) begin
          ph1_nxt = meas_phase_i;
          delay_nxt = probe_dn ? base_r - pdl_pkg::STEP_LO : base_r + pdl_pkg::STEP_LO;
          st_nxt = pdl_pkg::PDL_SLPS;
        end else begin
          do_adv = 1'b1;
        end
      end
      pdl_pkg::PDL_SLPM: begin
        if (slope_ok) begin
          delay_nxt = base_r;
          st_nxt = pdl_pkg::PDL_TRACK;
          locked_nxt = 1'b1;
          lost_nxt = 1'b0;
          ever_nxt = 1'b1;
        end else begin
          do_adv = 1'b1;
        end
      end
      pdl_pkg::PDL_TRACK: begin
        cnt_nxt = cnt_r + pdl_pkg::CNT_ONE;
        if (trk_eval) begin
          cnt_nxt = 8'h00;
          cur_ph_nxt = meas_phase_i;
          if (adev > pdl_pkg::LOSS_DEV) begin
            locked_nxt = 1'b0;
            lost_nxt = ever_r | lost_r;
            do_load = do_load | srch_r[pdl_pkg::SC_RESTART];
          end else if (adev <= pdl_pkg::RELOCK_DEV) begin
            locked_nxt = 1'b1;
            lost_nxt = 1'b0;
          end
          if (dev != 5'h00) begin
            if (!(dev[pdl_pkg::PH_MSB] ^ slope_r[pdl_pkg::SL_POS])) begin
              delay_nxt = (delay_tap_value_o > pdl_pkg::DLY_MAX - step) ?
                          pdl_pkg::DLY_MAX : delay_tap_value_o + step;
            end else begin
              delay_nxt = (delay_tap_value_o < step) ? pdl_pkg::DLY_MIN : delay_tap_value_o - step;
            end
          end
        end
      end
      pdl_pkg::PDL_FAIL: st_nxt = st_r;
      default: st_nxt = pdl_pkg::PDL_IDLE;
    endcase
    if (do_adv) begin
      if (adv_fail) begin
        if (srch_r[pdl_pkg::SC_RETRY]) begin
          do_load = 1'b1;
        end else begin
          st_nxt = pdl_pkg::PDL_FAIL;
          fail_nxt = 1'b1;
        end
      end else if (!can_up && !can_dn) begin
        wide_nxt = 1'b1;
      end else if (pick_up) begin
        up_nxt = up_r + pdl_pkg::STEP_LO;
        delay_nxt = up_r + pdl_pkg::STEP_LO;
        base_nxt = up_r + pdl_pkg::STEP_LO;
        dirup_nxt = 1'b0;
        st_nxt = pdl_pkg::PDL_SETTLE;
      end else begin
        dn_nxt = dn_r - pdl_pkg::STEP_LO;
        delay_nxt = dn_r - pdl_pkg::STEP_LO;
        base_nxt = dn_r - pdl_pkg::STEP_LO;
        dirup_nxt = 1'b1;
        st_nxt = pdl_pkg::PDL_SETTLE;
      end
    end
    if (do_load) begin
      st_nxt = pdl_pkg::PDL_SETTLE;
      cnt_nxt = 8'h00;
      delay_nxt = init_dly;
      base_nxt = init_dly;
      up_nxt = init_dly;
      dn_nxt = init_dly;
      dirup_nxt = 1'b1;
      wide_nxt = 1'b0;
      locked_nxt = 1'b0;
      fail_nxt = 1'b0;
      tmr_nxt = 32'h0;
    end
    if (stop) begin
      st_nxt = pdl_pkg::PDL_IDLE;
      cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= pdl_pkg::PDL_IDLE;
      cnt_r <= 8'h00;
      delay_tap_value_o <= 9'h000;
      base_r <= 9'h000;
      up_r <= 9'h000;
      dn_r <= 9'h000;
      dirup_r <= 1'b1;
      wide_r <= 1'b0;
      ph1_r <= 5'h00;
      cur_ph_r <= 5'h00;
      locked_r <= 1'b0;
      lost_r <= 1'b0;
      ever_r <= 1'b0;
      fail_r <= 1'b0;
      tmr_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      delay_tap_value_o <= delay_nxt;
      base_r <= base_nxt;
      up_r <= up_nxt;
      dn_r <= dn_nxt;
      dirup_r <= dirup_nxt;
      wide_r <= wide_nxt;
      ph1_r <= ph1_nxt;
      cur_ph_r <= cur_ph_nxt;
      locked_r <= locked_nxt;
      lost_r <= lost_nxt;
      ever_r <= ever_nxt;
      fail_r <= fail_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  a_delay_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    delay_tap_value_o <= pdl_pkg::DLY_MAX) else $error("delay tap out of range");
  a_start_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    start |=> (st_r == pdl_pkg::PDL_SETTLE) && (delay_tap_value_o == init_dly))
    else $error("search did not start at initial delay");
  a_track_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (st_r == pdl_pkg::PDL_SLPM && slope_ok && !start && !stop) |=> (st_r == pdl_pkg::PDL_TRACK) && locked_r)
    else $error("matched search did not enter locked tracking");
  a_loss_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (trk_eval && adev > pdl_pkg::LOSS_DEV && !start) |=> !locked_r && (lost_r == $past(ever_r | lost_r)))
    else $error("loss of lock not flagged");
  a_lost_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    $rose(lost_r) |-> $past(ever_r) && $past(trk_eval)) else $error("lost flag without prior lock");
  a_relock: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (trk_eval && adev <= pdl_pkg::RELOCK_DEV && !start) |=> locked_r && !lost_r) else $error("relock not flagged");
  a_fail_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (do_adv && adv_fail && !srch_r[pdl_pkg::SC_RETRY] && !start && !stop) |=> st_r == pdl_pkg::PDL_FAIL ##1
    st_r == pdl_pkg::PDL_FAIL) else $error("failed search did not stop");
  a_fail_retry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (do_adv && adv_fail && srch_r[pdl_pkg::SC_RETRY] && !stop) |=> st_r == pdl_pkg::PDL_SETTLE &&
    delay_tap_value_o == init_dly) else $error("failed search did not retry");
  a_restart_loss: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (trk_eval && adev > pdl_pkg::LOSS_DEV && srch_r[pdl_pkg::SC_RESTART] && !stop) |=> st_r == pdl_pkg::PDL_SETTLE)
    else $error("restart on loss not taken");
endmodule

/* core/pdl_pkg.sv */
// Shared constants, state type and helpers for the phase delay lock controller.
package pdl_pkg;
  localparam logic [6:0] A_IRQ_EN = 7'h03;
  localparam logic [6:0] A_IRQ_ST = 7'h04;
  localparam logic [6:0] A_SYNC_ST = 7'h21;
  localparam logic [6:0] A_PD_CTL = 7'h24;
  localparam logic [6:0] A_SLOPE = 7'h25;
  localparam logic [6:0] A_LOOP = 7'h26;
  localparam logic [6:0] A_TGT = 7'h27;
  localparam logic [6:0] A_DLY = 7'h28;
  localparam logic [6:0] A_SRCH = 7'h29;
  localparam logic [6:0] A_LSTAT = 7'h2a;
  localparam int LC_EN = 0;
  localparam int LC_GAIN = 1;
  localparam int LC_READ = 3;
  localparam int SC_EXACT = 7;
  localparam int SC_RETRY = 6;
  localparam int SC_RESTART = 5;
  localparam int GUARD_MSB = 4;
  localparam int GUARD_SHIFT = 3;
  localparam int SL_POS = 6;
  localparam int TP_DLY0 = 7;
  localparam int PH_MSB = 4;
  localparam int IRQ_W = 6;
  localparam logic [8:0] DLY_MAX = 9'h1b0;
  localparam logic [8:0] DLY_MIN = 9'h000;
  localparam logic [8:0] STEP_LO = 9'h001;
  localparam logic [8:0] STEP_HI = 9'h002;
  localparam logic [4:0] LOSS_DEV = 5'h04;
  localparam logic [4:0] RELOCK_DEV = 5'h03;
  localparam logic [4:0] TOL_DEV = 5'h01;
  localparam logic [7:0] SETTLE_CYC = 8'h10;
  localparam logic [7:0] TRACK_CYC = 8'h40;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam int unsigned LOCK_CYC_DEF = 180000;

  typedef enum logic [2:0] {
    PDL_IDLE = 3'h0,
    PDL_SETTLE = 3'h1,
    PDL_MEAS = 3'h3,
    PDL_SLPS = 3'h2,
    PDL_SLPM = 3'h6,
    PDL_TRACK = 3'h7,
    PDL_FAIL = 3'h5
  } pdl_state_e;

  // Wrapped phase difference, read as a signed 5-bit value.
  function automatic logic [4:0] phase_dev(input logic [4:0] a, input logic [4:0] b);
    phase_dev = a - b;
  endfunction

  function automatic logic [4:0] mag(input logic [4:0] d);
    mag = d[PH_MSB] ? 5'(-d) : d;
  endfunction
endpackage

/* core/pdl_spi_slave.sv */
// Serial configuration port slave: 16-bit frames, read/write flag and 7-bit address first.
`timescale 1ns/100ps
module pdl_spi_slave (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic csb_i,
  input wire logic sdi_i,
  input wire logic [7:0] rdata_i,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  logic sclk_q_r, sclk_q_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [6:0] sh_r, sh_nxt;
  logic [7:0] out_r, out_nxt;
  logic rd_r, rd_nxt, load_r, load_nxt;
  logic [6:0] addr_nxt;
  logic [7:0] wdata_nxt;
  logic wr_nxt, sdo_nxt, oe_nxt;
  logic rise, fall;

  assign rise = sclk_i && !sclk_q_r;
  assign fall = !sclk_i && sclk_q_r;

  always_comb begin
    sclk_q_nxt = sclk_i;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    out_nxt = out_r;
    rd_nxt = rd_r;
    load_nxt = 1'b0;
    addr_nxt = addr_o;
    wdata_nxt = wdata_o;
    wr_nxt = 1'b0;
    sdo_nxt = sdo_o;
    oe_nxt = !csb_i && rd_r && cnt_r[3];
    if (load_r) begin
      out_nxt = rdata_i;
    end
    if (csb_i) begin
      cnt_nxt = 4'h0;
      rd_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (rise) begin
      cnt_nxt = cnt_r + 4'h1;
      sh_nxt = {sh_r[5:0], sdi_i};
      if (cnt_r == 4'h0) begin
        rd_nxt = sdi_i;
      end
      if (cnt_r == 4'h7) begin
        addr_nxt = {sh_r[5:0], sdi_i};
        load_nxt = rd_r;
      end
      if (cnt_r == 4'hf && !rd_r) begin
        wdata_nxt = {sh_r, sdi_i};
        wr_nxt = 1'b1;
      end
    end else if (fall && rd_r && cnt_r[3]) begin
      sdo_nxt = out_r[7];
      out_nxt = {out_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 7'h00;
      out_r <= 8'h00;
      rd_r <= 1'b0;
      load_r <= 1'b0;
      addr_o <= 7'h00;
      wdata_o <= 8'h00;
      wr_o <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sclk_q_r <= sclk_q_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      out_r <= out_nxt;
      rd_r <= rd_nxt;
      load_r <= load_nxt;
      addr_o <= addr_nxt;
      wdata_o <= wdata_nxt;
      wr_o <= wr_nxt;
      sdo_o <= sdo_nxt;
      sdo_oe_o <= oe_nxt;
    end
  end
endmodule

/* core/pdl_irq.sv */
// Interrupt collector: edge-set sticky status, enable mirror and registered request.
`timescale 1ns/100ps
module pdl_irq (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] cond_i,
  input wire logic [5:0] en_i,
  output logic [5:0] status_o,
  output logic irq_o
);
  logic [5:0] cond_q_r, status_nxt, rise;
  logic irq_nxt;

  assign rise = cond_i & ~cond_q_r;

  always_comb begin
    status_nxt = (status_o | (rise & en_i)) & en_i;
    irq_nxt = |(status_nxt & en_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_q_r <= 6'h00;
      status_o <= 6'h00;
      irq_o <= 1'b0;
    end else begin
      cond_q_r <= cond_i;
      status_o <= status_nxt;
      irq_o <= irq_nxt;
    end
  end

  a_set_on_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    |(rise & en_i) |=> |status_o) else $error("status not set on rising condition");
  a_clear_on_dis: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 ((status_o & ~$past(en_i)) == 6'h00)) else $error("status kept while disabled");
  a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 (irq_o == |(status_o & $past(en_i)))) else $error("interrupt output mismatch");
endmodule

/* bench/pdl_phase_model.sv */
// Phase detector model: measured phase as a function of the delay tap setting.
`timescale 1ns/100ps
module pdl_phase_model (
  input wire logic [8:0] delay_i,
  input wire logic [4:0] shift_i,
  output logic [4:0] phase_o
);
  logic [8:0] span;
  // Phase falls as delay rises (negative slope); target phase 6 sits at taps 233 to 236.
  assign span = 9'h104 - delay_i;
  // The shift input models a clock disturbance that moves the phase away from lock.
  assign phase_o = span[6:2] + shift_i;
endmodule

/* bench/tb.sv */
// Self-checking testbench for the phase delay lock controller over its serial port.
`timescale 1ns/100ps
module tb;
  logic ref_clk, reset_n, sclk, csb, sdi, sdo, sdo_oe, irq;
  logic rcv_lk, rcv_ls, rcv_tr, al_lk, al_ls, al_tr;
  logic [4:0] phase, shift;
  logic [8:0] dly;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  pdl_phase_model model (.delay_i(dly), .shift_i(shift), .phase_o(phase));
  pdl_ctrl #(.LOCK_CYCLES(5000)) dut (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .spi_sclk_i(sclk), .spi_csb_i(csb), .spi_sdi_i(sdi),
    .meas_phase_i(phase), .receiver_locked_flag_i(rcv_lk), .receiver_lost_flag_i(rcv_ls),
    .receiver_tracking_flag_i(rcv_tr), .align_locked_flag_i(al_lk), .align_lost_flag_i(al_ls),
    .align_tracking_flag_i(al_tr), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .irq_o(irq),
    .delay_tap_value_o(dly));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, s);
    end
  endtask

  // One 16-bit frame: read flag, address, data; sclk phases of four clock cycles each.
  task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    csb = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = f[i];
      tick(4);
      sclk = 1'b1;
      if (i < 8) q[i] = sdo;
      if (i < 8 && rd) chk("sdo_enable", 8'h01, {7'h00, sdo_oe});
      tick(4);
      sclk = 1'b0;
    end
    tick(2);
    csb = 1'b1;
    tick(3);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, q);
    chk(name, e, q & m);
  endtask

  // Reads a register until its masked value lands in a window, at most forty times.
  task automatic poll(input string name, input logic [6:0] a, input logic [7:0] m, input logic [7:0] lo,
                      input logic [7:0] hi);
    logic [7:0] q;
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 40 && !hit; k++) begin
      spi(1'b1, a, 8'h00, q);
      hit = ((q & m) >= lo) && ((q & m) <= hi);
    end
    chk(name, 8'h01, {7'h00, hit});
  endtask

  task automatic wait_irq(input int n);
    for (int k = 0; k < n && irq !== 1'b1; k++) tick(1);
  endtask

  initial begin
    reset_n = 1'b0;
    sclk = 1'b0;
    csb = 1'b1;
    sdi = 1'b0;
    shift = 5'h00;
    {rcv_lk, rcv_ls, rcv_tr, al_lk, al_ls, al_tr} = 6'h00;
    tick(16);
    reset_n = 1'b1;
    tick(4);
    rd_chk("loop_control", pdl_pkg::A_LOOP, 8'hff, 8'h00);
    rd_chk("search_cfg", pdl_pkg::A_SRCH, 8'hff, 8'h00);
    rd_chk("unmapped", 7'h10, 8'hff, 8'h00);
    wr(pdl_pkg::A_LSTAT, 8'hff);
    rd_chk("loop_status_ro", pdl_pkg::A_LSTAT, 8'hff, 8'h00);
    $display("test reset_values done");
    wr(pdl_pkg::A_PD_CTL, 8'h30);
    wr(pdl_pkg::A_SLOPE, 8'h80);
    wr(pdl_pkg::A_TGT, 8'h46);
    wr(pdl_pkg::A_DLY, 8'h6c);
    wr(pdl_pkg::A_SRCH, 8'hcb);
    wr(pdl_pkg::A_IRQ_EN, 8'h04);
    rd_chk("detector_ctl", pdl_pkg::A_PD_CTL, 8'hff, 8'h30);
    wr(pdl_pkg::A_LOOP, 8'h03);
    wait_irq(20000);
    chk("irq_on_lock", 8'h01, {7'h00, irq});
    chk("delay_at_target", 8'h01, {7'h00, dly >= 9'h0e9 && dly <= 9'h0ec});
    rd_chk("locked_flag", pdl_pkg::A_LSTAT, 8'h03, 8'h01);
    rd_chk("lock_event", pdl_pkg::A_IRQ_ST, 8'hff, 8'h04);
    $display("test search_lock done");
    wr(pdl_pkg::A_IRQ_EN, 8'h00);
    chk("irq_cleared", 8'h00, {7'h00, irq});
    rd_chk("status_cleared", pdl_pkg::A_IRQ_ST, 8'hff, 8'h00);
    wr(pdl_pkg::A_IRQ_EN, 8'h04);
    chk("no_new_event", 8'h00, {7'h00, irq});
    $display("test irq_clear done");
    wr(pdl_pkg::A_LOOP, 8'h0b);
    // Writing loop control with the enable bit set restarts the search, so wait for lock again.
    poll("readback_relock", pdl_pkg::A_LSTAT, 8'h03, 8'h01, 8'h01);
    poll("readback_delay", pdl_pkg::A_DLY, 8'hff, 8'h74, 8'h76);
    rd_chk("readback_phase", pdl_pkg::A_TGT, 8'h1f, 8'h06);
    $display("test readback done");
    wr(pdl_pkg::A_IRQ_EN, 8'h08);
    shift = 5'h08;
    wait_irq(400);
    chk("irq_on_loss", 8'h01, {7'h00, irq});
    rd_chk("lost_flag", pdl_pkg::A_LSTAT, 8'h03, 8'h02);
    rd_chk("lost_event", pdl_pkg::A_IRQ_ST, 8'hff, 8'h08);
    poll("relocked", pdl_pkg::A_LSTAT, 8'h03, 8'h01, 8'h01);
    $display("test loss_relock done");
    wr(pdl_pkg::A_IRQ_EN, 8'h31);
    {rcv_lk, rcv_ls, rcv_tr, al_lk, al_ls, al_tr} = 6'h2f;
    rd_chk("live_status", pdl_pkg::A_SYNC_ST, 8'hff, 8'hb9);
    rd_chk("event_status", pdl_pkg::A_IRQ_ST, 8'hff, 8'h31);
    chk("irq_other_ctl", 8'h01, {7'h00, irq});
    wr(pdl_pkg::A_IRQ_EN, 8'h00);
    chk("irq_off", 8'h00, {7'h00, irq});
    $display("test live_status done");
    wr(pdl_pkg::A_SRCH, 8'heb);
    wr(pdl_pkg::A_IRQ_EN, 8'h08);
    shift = 5'h00;
    wait_irq(200);
    chk("irq_restart", 8'h01, {7'h00, irq});
    chk("restart_delay", 8'h01, {7'h00, dly == 9'h0d8});
    poll("restart_lock", pdl_pkg::A_LSTAT, 8'h03, 8'h01, 8'h01);
    $display("test restart_on_loss done");
    // A positive target slope is never met by the model, so the whole line is swept and the search fails.
    wr(pdl_pkg::A_SLOPE, 8'hc0);
    wr(pdl_pkg::A_SRCH, 8'h8b);
    wr(pdl_pkg::A_LOOP, 8'h03);
    tick(6500);
    poll("search_failed", pdl_pkg::A_LSTAT, 8'h0f, 8'h0c, 8'h0c);
    wr(pdl_pkg::A_SLOPE, 8'h80);
    wr(pdl_pkg::A_LOOP, 8'h03);
    poll("retry_lock", pdl_pkg::A_LSTAT, 8'h0f, 8'h01, 8'h01);
    $display("test search_fail done");
    wrap_up();
  end
endmodule
